// [shared/motor_mode_pkg.sv]
/*
 * Constants and types shared by the motor control mode selection logic.
 * Assumes a single 40 MHz core clock and the operating mode codes of a
 * CiA 402 style drive profile.
 */
package motor_mode_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;

   localparam int unsigned LOOP_SELECT_POS = 0;
   localparam int unsigned CURRENT_CUT_POS = 3;

   typedef logic signed [7:0] op_mode_t;
   localparam op_mode_t MODE_PROFILE_POS = 8'sh01;
   localparam op_mode_t MODE_VELOCITY = 8'sh02;
   localparam op_mode_t MODE_PROFILE_VEL = 8'sh03;
   localparam op_mode_t MODE_PROFILE_TORQUE = 8'sh04;
   localparam op_mode_t MODE_HOMING = 8'sh06;
   localparam op_mode_t MODE_INTERP_POS = 8'sh07;
   localparam op_mode_t MODE_CYC_POS = 8'sh08;
   localparam op_mode_t MODE_CYC_VEL = 8'sh09;
   localparam op_mode_t MODE_CYC_TORQUE = 8'sh0A;
   localparam op_mode_t MODE_CLOCK_DIR = 8'shFF;
   localparam op_mode_t MODE_AUTO_SETUP = 8'shFE;

   localparam op_mode_t HOME_BLOCK_MIN = 8'shFC;
   localparam op_mode_t HOME_BLOCK_MAX = 8'shFF;

   localparam logic [7:0] STORE_CAT_NONE = 8'h00;
   localparam logic [7:0] STORE_CAT_DRIVE = 8'h05;
   localparam logic [7:0] STORE_CAT_TUNING = 8'h06;

   localparam logic [7:0] PCT_FULL = 8'h64;
   localparam int unsigned GAIN_SHIFT = 8;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_COPY,
      ST_STORE_DRIVE,
      ST_STORE_TUNE,
      ST_DONE
   } commit_st_t;
endpackage

// [hdl/current_pi.sv]
/*
 * Proportional-integral current controller with output saturation.
 * Assumes set point and actual value share one signed scale; gains are
 * fixed point with GAIN_SHIFT fractional bits.
 */
`timescale 1ns/1ps
`default_nettype none
module current_pi
   import motor_mode_pkg::*;
#(
   parameter int W = 16
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic enable_in,
   input wire logic signed [W-1:0] setpoint_in,
   input wire logic signed [W-1:0] actual_in,
   input wire logic [W-1:0] kp_in,
   input wire logic [W-1:0] ki_in,
   output logic signed [W-1:0] out_out
);
   localparam int AW = 2 * W + 4;
   localparam logic signed [AW-1:0] MAXV = AW'((2 ** (W - 1)) - 1);
   localparam logic signed [AW-1:0] MINV = -MAXV - AW'(1);

   logic signed [W:0] err;
   logic signed [AW-1:0] prop, integ_d, integ_q, sum, shifted;
   logic sat;

   // Error between set point and measured value drives both terms.
   always_comb begin
      err = {setpoint_in[W-1], setpoint_in} - {actual_in[W-1], actual_in};
      prop = AW'(err) * AW'($signed({1'b0, kp_in}));
      integ_d = integ_q + AW'(err) * AW'($signed({1'b0, ki_in}));
      sum = prop + integ_q;
      shifted = sum >>> GAIN_SHIFT;
      sat = (shifted > MAXV) || (shifted < MINV);
   end

   // The integrator freezes while the output saturates to avoid windup.
   always_ff @(posedge core_clk_in) begin
      if (rst_in || !enable_in) begin
         integ_q <= '0;
      end else if (!sat) begin
         integ_q <= integ_d;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in || !enable_in) begin
         out_out <= '0;
      end else if (shifted > MAXV) begin
         out_out <= MAXV[W-1:0];
      end else if (shifted < MINV) begin
         out_out <= MINV[W-1:0];
      end else begin
         out_out <= shifted[W-1:0];
      end
   end
endmodule
`default_nettype wire

// [hdl/motor_control_mode_select.sv]
/*
 * Control mode selection, open loop current handling with standstill
 * reduction, closed loop current control and auto setup commit sequence.
 * Assumes all inputs are synchronous to core_clk_in and that the storage
 * engine acknowledges each category request with a one-cycle store_ack_in.
 */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - After successful auto setup copy measured values, store drive and tuning categories.
// - Auto setup invalidates coordinates; only a restart makes them valid again.
// - Open loop only for steppers; BLDC motors always run closed loop.
// - Profile torque and cyclic torque modes refused in open loop.
// - Block homing methods refused in open loop; other methods stay allowed.
// - Open loop drives full set current at all speeds regardless of load.
// - Submode bit 0 cleared selects open loop control.
// - Submode bit 3 set enables standstill current reduction.
// - Reduction starts only after the configured idle time in milliseconds.
// - Reduced current is the configured factor of the rated current.
// - Maximum current is in milliamperes and limits winding current.
// - Closed loop compares actual with set point and corrects deviation.
// - Current controller has programmable proportional and integral gains.
// - Status bit 12 shows auto setup ended; target bit shows index found.
module motor_control_mode_select
   import motor_mode_pkg::*;
#(
   parameter int W = 16,
   parameter int PW = 32,
   parameter int unsigned MS_CYCLES_P = MS_CYCLES
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [31:0] drive_submode_in,
   input wire logic motor_bldc_in,
   input wire logic [7:0] pole_pairs_in,
   input wire logic signed [7:0] op_mode_req_in,
   input wire logic signed [7:0] homing_method_in,
   input wire logic [W-1:0] max_current_ma_in,
   input wire logic [15:0] idle_time_ms_in,
   input wire logic [7:0] reduce_pct_in,
   input wire logic [W-1:0] kp_in,
   input wire logic [W-1:0] ki_in,
   input wire logic signed [W-1:0] current_setpoint_in,
   input wire logic signed [W-1:0] current_actual_in,
   input wire logic standstill_in,
   input wire logic motion_cmd_in,
   input wire logic autosetup_start_in,
   input wire logic autosetup_done_in,
   input wire logic autosetup_ok_in,
   input wire logic index_found_in,
   input wire logic [PW-1:0] measured_param_in,
   input wire logic store_ack_in,
   output logic closed_loop_out,
   output logic mode_allowed_out,
   output logic homing_allowed_out,
   output logic reduce_active_out,
   output logic [W-1:0] current_set_out,
   output logic signed [W-1:0] winding_cmd_out,
   output logic motion_start_out,
   output logic [7:0] pole_pairs_out,
   output logic [PW-1:0] param_copy_out,
   output logic param_copy_stb_out,
   output logic store_req_out,
   output logic [7:0] store_cat_out,
   output logic coord_valid_out,
   output logic setup_done_out,
   output logic target_flag_out
);
   localparam int PSW = $clog2(MS_CYCLES_P + 1);

   logic loop_select_bit, standstill_current_cut_bit;
   logic closed_d, torque_mode, block_homing, run_idle, reduce_d;
   logic [PSW-1:0] presc_q;
   logic [15:0] ms_q;
   logic [W+7:0] reduced_prod;
   logic [W-1:0] reduced_w;
   logic signed [W-1:0] pi_out, limit_pos;
   logic index_q;
   commit_st_t st_q;

   assign loop_select_bit = drive_submode_in[LOOP_SELECT_POS];
   assign standstill_current_cut_bit = drive_submode_in[CURRENT_CUT_POS];

   always_comb begin
      closed_d = loop_select_bit || motor_bldc_in;
      torque_mode = (op_mode_req_in == MODE_PROFILE_TORQUE) || (op_mode_req_in == MODE_CYC_TORQUE);
      block_homing = (homing_method_in >= HOME_BLOCK_MIN) && (homing_method_in <= HOME_BLOCK_MAX);
      run_idle = !closed_d && standstill_current_cut_bit && standstill_in && !motion_cmd_in;
      reduce_d = run_idle && (ms_q >= idle_time_ms_in);
      reduced_prod = (W + 8)'(max_current_ma_in) * (W + 8)'(reduce_pct_in);
      reduced_w = (reduce_pct_in >= PCT_FULL) ? max_current_ma_in : W'(reduced_prod / (W + 8)'(PCT_FULL));
      limit_pos = $signed({1'b0, max_current_ma_in[W-2:0]});
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         closed_loop_out <= 1'b0;
         mode_allowed_out <= 1'b0;
         homing_allowed_out <= 1'b0;
         pole_pairs_out <= '0;
      end else begin
         closed_loop_out <= closed_d;
         mode_allowed_out <= closed_d ||
            !(torque_mode || ((op_mode_req_in == MODE_HOMING) && block_homing));
         homing_allowed_out <= closed_d || !block_homing;
         pole_pairs_out <= pole_pairs_in;
      end
   end

   // Idle timer: a millisecond prescaler and a saturating millisecond count.
   always_ff @(posedge core_clk_in) begin
      if (rst_in || !run_idle) begin
         presc_q <= '0;
         ms_q <= '0;
      end else if (presc_q == PSW'(MS_CYCLES_P - 1)) begin
         presc_q <= '0;
         if (ms_q != 16'hFFFF) begin
            ms_q <= ms_q + 16'h0001;
         end
      end else begin
         presc_q <= presc_q + PSW'(1);
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         reduce_active_out <= 1'b0;
         current_set_out <= '0;
         motion_start_out <= 1'b0;
      end else begin
         reduce_active_out <= reduce_d;
         current_set_out <= reduce_d ? reduced_w : max_current_ma_in;
         motion_start_out <= motion_cmd_in;
      end
   end

   current_pi #(
      .W(W)
   ) u_pi (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .enable_in(closed_loop_out),
      .setpoint_in(current_setpoint_in),
      .actual_in(current_actual_in),
      .kp_in(kp_in),
      .ki_in(ki_in),
      .out_out(pi_out)
   );

   // Closed loop output is limited to the maximum current in both signs.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         winding_cmd_out <= '0;
      end else if (!closed_loop_out) begin
         winding_cmd_out <= $signed({1'b0, current_set_out[W-2:0]});
      end else if (pi_out > limit_pos) begin
         winding_cmd_out <= limit_pos;
      end else if (pi_out < -limit_pos) begin
         winding_cmd_out <= -limit_pos;
      end else begin
         winding_cmd_out <= pi_out;
      end
   end

   // Auto setup commit: copy, store drive, store tuning, then report.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         st_q <= ST_IDLE;
         index_q <= 1'b0;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (autosetup_done_in) begin
                  index_q <= index_found_in;
                  st_q <= autosetup_ok_in ? ST_COPY : ST_DONE;
               end
            end
            ST_COPY: st_q <= ST_STORE_DRIVE;
            ST_STORE_DRIVE: if (store_ack_in) st_q <= ST_STORE_TUNE;
            ST_STORE_TUNE: if (store_ack_in) st_q <= ST_DONE;
            ST_DONE: st_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         param_copy_out <= '0;
         param_copy_stb_out <= 1'b0;
         store_req_out <= 1'b0;
         store_cat_out <= STORE_CAT_NONE;
      end else begin
         param_copy_stb_out <= (st_q == ST_IDLE) && autosetup_done_in && autosetup_ok_in;
         if ((st_q == ST_IDLE) && autosetup_done_in && autosetup_ok_in) begin
            param_copy_out <= measured_param_in;
         end
         if (st_q == ST_COPY) begin
            store_req_out <= 1'b1;
            store_cat_out <= STORE_CAT_DRIVE;
         end else if ((st_q == ST_STORE_DRIVE) && store_ack_in) begin
            store_cat_out <= STORE_CAT_TUNING;
         end else if ((st_q == ST_STORE_TUNE) && store_ack_in) begin
            store_req_out <= 1'b0;
            store_cat_out <= STORE_CAT_NONE;
         end
      end
   end

   // The completion set wins over a coinciding new start.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         coord_valid_out <= 1'b1;
         setup_done_out <= 1'b0;
         target_flag_out <= 1'b0;
      end else begin
         if (autosetup_start_in) begin
            setup_done_out <= 1'b0;
            target_flag_out <= 1'b0;
         end
         if (st_q == ST_DONE) begin
            coord_valid_out <= 1'b0;
            setup_done_out <= 1'b1;
            target_flag_out <= index_q;
         end
      end
   end

   bldc_closed_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      motor_bldc_in |=> closed_loop_out)
      else $error("BLDC motor left in open loop");
   open_select_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (!motor_bldc_in && !loop_select_bit) |=> !closed_loop_out)
      else $error("Open loop not selected");
   torque_block_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (!closed_d && torque_mode) |=> !mode_allowed_out)
      else $error("Torque mode allowed in open loop");
   home_block_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (!closed_d && block_homing) |=> !homing_allowed_out)
      else $error("Block homing allowed in open loop");
   // The sampled reset keeps the edge that releases reset out, since the register still holds its reset value there.
   full_current_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (!rst_in && !closed_d && !reduce_d) |=> (current_set_out == $past(max_current_ma_in)))
      else $error("Open loop current not full");
   reduce_value_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      reduce_d |=> (reduce_active_out && current_set_out == $past(reduced_w)))
      else $error("Wrong reduced current");
   idle_wait_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      $rose(reduce_active_out) |-> ($past(ms_q) >= $past(idle_time_ms_in)))
      else $error("Reduction before idle time");
   cut_enable_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !standstill_current_cut_bit |=> !reduce_active_out)
      else $error("Reduction while disabled");
   motion_restore_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      motion_cmd_in |=> (!reduce_active_out && motion_start_out && ms_q == 16'h0000))
      else $error("Motion kept reduced current");
   commit_seq_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (st_q == ST_COPY) |=> (store_req_out && store_cat_out == STORE_CAT_DRIVE))
      else $error("Drive store not requested");
   coord_lost_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (st_q == ST_DONE) |=> (!coord_valid_out ##1 !coord_valid_out))
      else $error("Coordinates still valid");
   done_flag_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (st_q == ST_DONE) |=> (setup_done_out && target_flag_out == $past(index_q)))
      else $error("Setup done not reported");
endmodule
`default_nettype wire

// [bench/motor_model.sv]
/*
 * Far side model: winding feedback and the storage engine that takes
 * the commit requests of auto setup.
 * Assumes the core clock of the block and its synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module motor_model (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic signed [15:0] winding_cmd_in,
   input wire logic store_req_in,
   input wire logic [7:0] store_cat_in,
   output logic signed [15:0] current_actual_out,
   output logic store_ack_out
);
   logic [1:0] cnt_q;
   logic [7:0] last_q;

   // The winding answers with half of the command, one cycle late.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) current_actual_out <= 16'h0000;
      else current_actual_out <= winding_cmd_in >>> 1;
   end

   // Each category is acknowledged once, three cycles after it is asked for.
   always_ff @(posedge core_clk_in) begin
      store_ack_out <= 1'b0;
      if (rst_in || !store_req_in) begin
         cnt_q <= 2'h0;
         last_q <= 8'h00;
      end else if (store_cat_in != 8'h00 && store_cat_in != last_q) begin
         cnt_q <= cnt_q + 2'h1;
         if (cnt_q == 2'h2) begin
            store_ack_out <= 1'b1;
            last_q <= store_cat_in;
            cnt_q <= 2'h0;
         end
      end
   end
endmodule
`default_nettype wire

// [bench/motor_control_mode_select_tb.sv]
/*
 * Self-checking bench for the mode selection block and its far side model.
 * Assumes the millisecond prescaler is shortened to 4 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module motor_control_mode_select_tb
   import motor_mode_pkg::*;
;
   logic clk = 0, rst = 1, bldc = 0, st = 0, mc = 0, as_st = 0, as_dn = 0, as_ok = 0, idx = 0;
   logic [31:0] sub = 0, mp = 0;
   logic [7:0] pp = 8'h32, pct = 8'h32;
   op_mode_t mode = MODE_PROFILE_POS, hm = 8'sh01;
   logic [15:0] maxc = 16'h03E8, idle = 16'h0002, kp = 16'h0100, ki = 16'h0000;
   logic signed [15:0] sp = 0, act, wcmd;
   logic ack, cl, ma, ha, ra, ms, pcs, sreq, cv, sd, tf;
   logic [15:0] cset;
   logic [7:0] ppo, scat;
   logic [31:0] pco;
   int err_total = 0, n_tests = 0, i;
   op_mode_t ml[11] = '{MODE_PROFILE_POS, MODE_VELOCITY, MODE_PROFILE_VEL, MODE_PROFILE_TORQUE, MODE_HOMING,
      MODE_INTERP_POS, MODE_CYC_POS, MODE_CYC_VEL, MODE_CYC_TORQUE, MODE_CLOCK_DIR, MODE_AUTO_SETUP};

   motor_control_mode_select #(.MS_CYCLES_P(4)) dut (.core_clk_in(clk), .rst_in(rst), .drive_submode_in(sub),
      .motor_bldc_in(bldc), .pole_pairs_in(pp), .op_mode_req_in(mode), .homing_method_in(hm),
      .max_current_ma_in(maxc), .idle_time_ms_in(idle), .reduce_pct_in(pct), .kp_in(kp), .ki_in(ki),
      .current_setpoint_in(sp), .current_actual_in(act), .standstill_in(st), .motion_cmd_in(mc),
      .autosetup_start_in(as_st), .autosetup_done_in(as_dn), .autosetup_ok_in(as_ok), .index_found_in(idx),
      .measured_param_in(mp), .store_ack_in(ack), .closed_loop_out(cl), .mode_allowed_out(ma),
      .homing_allowed_out(ha), .reduce_active_out(ra), .current_set_out(cset), .winding_cmd_out(wcmd),
      .motion_start_out(ms), .pole_pairs_out(ppo), .param_copy_out(pco), .param_copy_stb_out(pcs),
      .store_req_out(sreq), .store_cat_out(scat), .coord_valid_out(cv), .setup_done_out(sd),
      .target_flag_out(tf));
   motor_model model (.core_clk_in(clk), .rst_in(rst), .winding_cmd_in(wcmd), .store_req_in(sreq),
      .store_cat_in(scat), .current_actual_out(act), .store_ack_out(ack));

   initial begin
      forever #12.5 clk = ~clk;
   end

   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task chk_bit(input string n, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %b seen %b", n, e, g);
      end
   endtask

   task chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task t_modes;
      for (int k = 0; k < 3; k++) begin
         for (int m = 0; m < 11; m++) begin
            @(posedge clk);
            sub <= {31'h0, k == 1};
            bldc <= k == 2;
            mode <= ml[m];
            step(2);
            chk_bit("closed_loop", k != 0, cl);
            chk_bit("mode_allowed", k != 0 || (ml[m] != MODE_PROFILE_TORQUE && ml[m] != MODE_CYC_TORQUE), ma);
         end
      end
   endtask

   task t_homing;
      @(posedge clk);
      sub <= 0;
      bldc <= 0;
      mode <= MODE_HOMING;
      for (int j = -5; j < 3; j++) begin
         @(posedge clk);
         hm <= j[7:0];
         step(2);
         chk_bit("homing_allowed", !(j >= -4 && j <= -1), ha);
         chk_bit("homing_mode", !(j >= -4 && j <= -1), ma);
      end
      @(posedge clk);
      sub <= 1;
      hm <= -8'sd2;
      step(2);
      chk_bit("homing_closed", 1'b1, ha);
      chk_bit("homing_mode_closed", 1'b1, ma);
      @(posedge clk);
      hm <= 8'sh01;
   endtask

   task t_reduce;
      @(posedge clk);
      sub <= 32'h0000_0008;
      st <= 1;
      // Open loop motion runs here in profile position mode; open loop also allows the cyclic position and velocity modes.
      mode <= MODE_PROFILE_POS;
      step(3);
      chk_word("full_current", 32'(maxc), 32'(cset));
      chk_word("winding_open", 32'(maxc), 32'(wcmd));
      chk_bit("early_reduce", 1'b0, ra);
      step(5);
      chk_bit("still_idle", 1'b0, ra);
      step(1);
      chk_bit("reduce_on", 1'b1, ra);
      chk_word("reduced_current", 32'h0000_01F4, 32'(cset));
      @(posedge clk);
      mc <= 1;
      @(posedge clk);
      mc <= 0;
      #1;
      chk_bit("reduce_off", 1'b0, ra);
      chk_bit("motion_start", 1'b1, ms);
      chk_word("restored_current", 32'(maxc), 32'(cset));
      step(4);
      chk_bit("timer_restart", 1'b0, ra);
      step(5);
      chk_bit("reduce_again", 1'b1, ra);
      @(posedge clk);
      st <= 0;
   endtask

   task t_closed;
      @(posedge clk);
      sub <= 1;
      sp <= 16'sd100;
      step(30);
      chk_bit("pi_positive", 1'b1, wcmd > 0 && wcmd <= 100);
      @(posedge clk);
      sp <= -16'sd100;
      step(30);
      chk_bit("pi_negative", 1'b1, wcmd < 0 && wcmd >= -100);
      // With an integral term the actual value settles on the set point, so the command doubles it.
      @(posedge clk);
      ki <= 16'h0010;
      sp <= 16'sd100;
      step(400);
      chk_bit("pi_integral", 1'b1, wcmd >= 190 && wcmd <= 210);
      @(posedge clk);
      maxc <= 16'h0064;
      step(20);
      chk_word("winding_limit", 32'h0000_0064, 32'(wcmd));
      @(posedge clk);
      maxc <= 16'h03E8;
      ki <= 16'h0000;
   endtask

   task t_setup;
      @(posedge clk);
      as_ok <= 1;
      idx <= 1;
      mp <= 32'hA5C3_1E0F;
      as_dn <= 1;
      @(posedge clk);
      as_dn <= 0;
      #1;
      chk_bit("copy_strobe", 1'b1, pcs);
      chk_word("copy_value", 32'hA5C3_1E0F, pco);
      for (i = 0; i < 20 && scat !== STORE_CAT_DRIVE; i++) step(1);
      chk_bit("store_drive", 1'b1, sreq && scat === STORE_CAT_DRIVE);
      for (i = 0; i < 20 && scat !== STORE_CAT_TUNING; i++) step(1);
      chk_bit("store_tuning", 1'b1, sreq && scat === STORE_CAT_TUNING);
      for (i = 0; i < 20 && sd !== 1'b1; i++) step(1);
      chk_bit("setup_done", 1'b1, sd);
      chk_bit("target_flag", 1'b1, tf);
      chk_bit("coord_valid", 1'b0, cv);
      chk_bit("store_released", 1'b0, sreq);
   endtask

   task t_fail;
      @(posedge clk);
      as_st <= 1;
      @(posedge clk);
      as_st <= 0;
      #1;
      chk_bit("start_clears", 1'b0, sd);
      chk_bit("start_clears_target", 1'b0, tf);
      @(posedge clk);
      as_ok <= 0;
      idx <= 0;
      mp <= 32'h0000_0000;
      as_dn <= 1;
      @(posedge clk);
      as_dn <= 0;
      as_st <= 1;
      #1;
      chk_bit("fail_no_copy", 1'b0, pcs);
      @(posedge clk);
      as_st <= 0;
      #1;
      chk_bit("fail_done", 1'b1, sd);
      chk_bit("fail_target", 1'b0, tf);
      chk_bit("fail_no_store", 1'b0, sreq);
      chk_word("copy_kept", 32'hA5C3_1E0F, pco);
      chk_bit("fail_coord", 1'b0, cv);
   endtask

   task t_restart;
      @(posedge clk);
      rst <= 1;
      @(posedge clk);
      rst <= 0;
      #1;
      chk_bit("restart_coord", 1'b1, cv);
      chk_bit("restart_done", 1'b0, sd);
   endtask

   task wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      step(5);
      chk_bit("reset_coord", 1'b1, cv);
      chk_bit("reset_done", 1'b0, sd);
      @(posedge clk);
      rst <= 0;
      step(2);
      chk_word("pole_pairs", 32'h32, 32'(ppo));
      t_modes();
      t_homing();
      t_reduce();
      t_closed();
      t_setup();
      t_fail();
      t_restart();
      wrap_up();
   end

   initial begin
      #(20000 * 25);
      err_total++;
      wrap_up();
   end
endmodule
`default_nettype wire
